// ==== rtl/pin_option_routing.v ====
// strap decode, pixel routing onto eight lanes, panel power and gpio control
//
// Behaviour
// [RULE1] pixel-mode strap low: one in, one out; lanes 0-3 only, second clock off.
// [RULE2] pixel-mode strap high: two pixels in and out; all lanes, both clocks.
// [RULE3] pixel-mode strap mid: single in, dual out; all lanes and both clocks.
// [RULE4] single/single: pixel bits 0-11 go to lanes 0-3.
// [RULE5] single/dual: first of two pixels to lanes 0-3, second to lanes 4-7.
// [RULE6] dual/dual: bits 0-11 to lanes 0-3, bits 12-23 to lanes 4-7.
// [RULE7] six-bit panels leave lane 3, and lane 7 in dual modes, unconnected.
// [RULE8] colour strap low: conventional mapping; high: non-conventional for 24/48 bit.
// [RULE9] edge strap high selects rising primary edge, low selects falling.
// [RULE10] four panel-select straps form a binary index 0-15, first strap lsb.
// [RULE11] panel-select straps are captured into a readable four-bit field.
// [RULE12] second forwarded clock copies the first whenever enabled.
// [RULE13] clock-invert strap 0 uses pixel clock as is, 1 inverts it.
// [RULE14] all three gpio pins come up as inputs.
// [RULE15] gpio outputs float while the scaler is powered down.
// [RULE16] panel power enable output set by software.
// [RULE17] backlight enable output set by software.
// [RULE18] address straps form the low three bits of the slave address.
// [RULE19] balance and test straps held low, legacy outputs left open.
// [RULE20] upper four slave address bits are fixed at 0111.
// [RULE21] address straps latched at first bus access, later changes ignored.
// [RULE22] pixels are valid only while valid input high, if qualify bit set.
// [RULE23] straps accepted only once stable and never while pixels stream.
// [RULE24] three-level strap always decodes to exactly one mode.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "pin_option_map.vh"

module pin_option_routing (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        pixel_clock_in,
	input  wire [23:0] pixel_input_bus,
	input  wire        pixel_valid_in,
	input  wire [1:0]  pixel_mode_strap,
	input  wire        colour_map_strap,
	input  wire        edge_select_strap,
	input  wire        input_clock_invert_strap,
	input  wire [3:0]  panel_select_straps,
	input  wire [2:0]  slave_addr_straps,
	input  wire        balance_mode_strap,
	input  wire [2:0]  general_io_in,
	output reg  [2:0]  general_io_out,
	output reg  [2:0]  general_io_oe_n,
	output reg  [11:0] lane_low_word,
	output reg  [11:0] lane_high_word,
	output reg  [7:0]  lane_enable,
	output reg         first_forwarded_clock,
	output reg         second_forwarded_clock,
	output reg         word_strobe,
	output reg         panel_power_enable_out,
	output reg         backlight_enable_out,
	output reg         primary_sampling_edge
);

	// ---------------------------------------------------------------
	// synchronisers for pins from outside the pclk domain
	// ---------------------------------------------------------------
	reg  [41:0] sync_a;
	reg  [41:0] sync_b;
	wire [41:0] raw_pins = {pixel_clock_in, pixel_valid_in, pixel_input_bus,
		pixel_mode_strap, colour_map_strap, edge_select_strap,
		input_clock_invert_strap, panel_select_straps, slave_addr_straps,
		balance_mode_strap, general_io_in};

	// two flops each; only sync_b is looked at by logic
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 42'h0;
			sync_b <= 42'h0;
		end else begin
			sync_a <= raw_pins;
			sync_b <= sync_a;
		end
	end

	// strap word: mode, colour, edge, invert, panel, balance, spare bit zero
	wire        s_clk    = sync_b[41];
	wire        s_valid  = sync_b[40];
	wire [23:0] s_pixel  = sync_b[39:16];
	wire [10:0] s_straps = {sync_b[15:7], sync_b[3], 1'b0};
	wire [2:0]  s_addr   = sync_b[6:4];
	wire [2:0]  s_gpio   = sync_b[2:0];

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	reg  [3:0] ctrl;
	reg  [2:0] gpio_dir;
	reg  [2:0] gpio_out;
	reg  [2:0] addr_latch;
	reg        addr_taken;

	wire access = psel & penable;
	wire wr_en  = access & pwrite;

	// writes take effect in the access cycle; pready is always high there
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl     <= `CTRL_RESET;
			gpio_dir <= `GPIO_DIR_RESET;            // [RULE14]
			gpio_out <= `GPIO_OUT_RESET;
		end else if (wr_en) begin
			case (paddr)
			`OFS_CTRL: ctrl <= pwdata[3:0];
			`OFS_GPIO_DIR: gpio_dir <= pwdata[2:0];
			`OFS_GPIO_OUT: gpio_out <= pwdata[2:0];
			default: ctrl <= ctrl;
			endcase
		end
	end

	// address straps frozen at the first bus access of any kind
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_latch <= 3'h0;
			addr_taken <= 1'b0;
		end else if (psel && !addr_taken) begin
			addr_latch <= s_addr;                  // [RULE21]
			addr_taken <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// strap acceptance
	// ---------------------------------------------------------------
	reg [10:0] strap_prev;
	reg [10:0] strap_live;
	reg [3:0]  settle;
	reg        streaming;

	// a strap is taken once steady, and never while pixels stream
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_prev <= 11'h0;
			strap_live <= 11'h0;
			settle     <= 4'h0;
		end else begin
			strap_prev <= s_straps;
			if (s_straps != strap_prev)
				settle <= 4'h0;
			else if (settle != `STRAP_SETTLE)
				settle <= settle + 4'h1;
			else if (!streaming)
				strap_live <= s_straps;            // [RULE23]
		end
	end

	wire [1:0] mode_pins    = strap_live[10:9];
	wire       colour_hi    = strap_live[8];
	wire       edge_rise    = strap_live[7];      // [RULE9]
	wire       clk_invert   = strap_live[6];
	wire [3:0] panel_index  = strap_live[5:2];    // [RULE10]

	// three-level decode; the odd comparator code falls to the mid mode
	function [1:0] decode_mode;
		input [1:0] pins;
		begin
			case (pins)
			`STRAP_LOW:  decode_mode = `MODE_SISO;   // [RULE1]
			`STRAP_HIGH: decode_mode = `MODE_DIDO;   // [RULE2]
			default:     decode_mode = `MODE_SIDO;   // [RULE3] [RULE24]
			endcase
		end
	endfunction

	wire [1:0] mode = decode_mode(mode_pins);

	// non-conventional mapping swaps the msb/lsb colour groups within a pixel
	function [11:0] map_colour;
		input [11:0] pix;
		input        swap;
		begin
			map_colour = swap ? {pix[5:0], pix[11:6]} : pix;
		end
	endfunction

	// ---------------------------------------------------------------
	// pixel clock edge detect and routing
	// ---------------------------------------------------------------
	reg        clk_prev;
	reg        phase;
	reg [11:0] first_pixel;
	wire       eff_clk   = s_clk ^ clk_invert;    // [RULE13]
	wire       rise      = eff_clk & ~clk_prev;
	wire       fall      = ~eff_clk & clk_prev;
	wire       samp_edge = edge_rise ? rise : fall;
	wire       take      = samp_edge & (s_valid | ~ctrl[`CTRL_QUALIFY]); // [RULE22]
	wire [11:0] pix_lo   = map_colour(s_pixel[11:0], colour_hi);          // [RULE8]
	wire [11:0] pix_hi   = map_colour(s_pixel[23:12], colour_hi);

	// lane words follow the sampling edges; forwarded clocks copy the effective pixel clock every cycle, the second one not in single/single mode
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_prev               <= 1'b0;
			phase                  <= 1'b0;
			first_pixel            <= 12'h0;
			lane_low_word          <= 12'h0;
			lane_high_word         <= 12'h0;
			word_strobe            <= 1'b0;
			streaming              <= 1'b0;
			first_forwarded_clock  <= 1'b0;
			second_forwarded_clock <= 1'b0;
			lane_enable            <= 8'h00;
			primary_sampling_edge  <= 1'b0;
		end else begin
			clk_prev              <= eff_clk;
			word_strobe           <= 1'b0;
			primary_sampling_edge <= edge_rise;
			first_forwarded_clock <= eff_clk;
			second_forwarded_clock <= (mode != `MODE_SISO) ? eff_clk : 1'b0; // [RULE12]
			lane_enable <= (mode == `MODE_SISO) ? 8'h0F : 8'hFF;             // [RULE1]
			if (samp_edge)
				streaming <= take;
			if (take) begin
				case (mode)
				`MODE_SISO: begin
					lane_low_word <= pix_lo;                   // [RULE4]
					word_strobe   <= 1'b1;
				end
				`MODE_SIDO: begin
					if (!phase) begin
						first_pixel <= pix_lo;
					end else begin
						lane_low_word  <= first_pixel;           // [RULE5]
						lane_high_word <= pix_lo;
						word_strobe    <= 1'b1;
					end
					phase <= ~phase;
				end
				`MODE_DIDO: begin
					lane_low_word  <= pix_lo;                  // [RULE6]
					lane_high_word <= pix_hi;
					word_strobe    <= 1'b1;
				end
				default: phase <= 1'b0;
				endcase
			end else if (samp_edge) begin
				phase <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// panel, backlight and gpio pins
	// ---------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_power_enable_out <= 1'b0;
			backlight_enable_out   <= 1'b0;
			general_io_out         <= 3'h0;
			general_io_oe_n        <= 3'h7;
		end else begin
			panel_power_enable_out <= ctrl[`CTRL_PANEL_PWR];  // [RULE16]
			backlight_enable_out   <= ctrl[`CTRL_BACKLIGHT];  // [RULE17]
			general_io_out         <= gpio_out;
			// outputs released while the scaler sleeps
			general_io_oe_n <= ctrl[`CTRL_SCALER_DOWN] ? 3'h7 : ~gpio_dir; // [RULE15]
		end
	end

	// ---------------------------------------------------------------
	// apb read data and answer
	// ---------------------------------------------------------------
	reg [31:0] next_prdata;
	reg        next_err;

	always @* begin
		next_prdata = 32'h0;
		next_err    = 1'b0;
		case (paddr)
		`OFS_CTRL:       next_prdata = {28'h0, ctrl};
		`OFS_GPIO_DIR:   next_prdata = {29'h0, gpio_dir};
		`OFS_GPIO_OUT:   next_prdata = {29'h0, gpio_out};
		`OFS_STATUS:     next_prdata = {24'h0, streaming, phase, s_gpio, mode, addr_taken};
		`OFS_STRAPS:     next_prdata = {24'h0, colour_hi, edge_rise, clk_invert,
			strap_live[1], panel_index};                                // [RULE11]
		`OFS_SLAVE_ADDR: next_prdata = {25'h0, `SLAVE_ADDR_UPPER, addr_latch}; // [RULE18] [RULE20]
		default:         next_err    = 1'b1;
		endcase
	end

	// answer one cycle after setup: pready rises in the first access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & next_err;
			prdata  <= (psel & ~penable & ~pwrite) ? next_prdata : 32'h0;
		end
	end

endmodule

// ==== inc/pin_option_map.vh ====
// register map, field positions, reset values and mode codes of the pin option block
`ifndef PIN_OPTION_MAP_VH
`define PIN_OPTION_MAP_VH

// register byte offsets
`define OFS_CTRL        12'h000
`define OFS_GPIO_DIR    12'h004
`define OFS_GPIO_OUT    12'h008
`define OFS_STATUS      12'h00C
`define OFS_STRAPS      12'h010
`define OFS_SLAVE_ADDR  12'h014

// control register fields
`define CTRL_PANEL_PWR    0
`define CTRL_BACKLIGHT    1
`define CTRL_SCALER_DOWN  2
`define CTRL_QUALIFY      3
`define CTRL_RESET        4'h8

// gpio registers
`define GPIO_DIR_RESET    3'h0
`define GPIO_OUT_RESET    3'h0

// pixel mode codes
`define MODE_SISO    2'h0
`define MODE_SIDO    2'h1
`define MODE_DIDO    2'h2

// three-level strap encoding on two comparator inputs
`define STRAP_LOW    2'h0
`define STRAP_MID    2'h1
`define STRAP_HIGH   2'h3

// fixed upper bits of the serial slave address
`define SLAVE_ADDR_UPPER  4'h7

// cycles a strap must stay unchanged before it is accepted
`define STRAP_SETTLE      4'hF

`endif

// ==== verif/pin_option_checker.sv ====
// concurrent checks on the pin option block ports
`timescale 1ns/1ps
`include "pin_option_map.vh"
module pin_option_checker (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire [2:0]  general_io_oe_n,
	input wire [11:0] lane_low_word,
	input wire [7:0]  lane_enable,
	input wire        first_forwarded_clock,
	input wire        second_forwarded_clock,
	input wire        word_strobe,
	input wire        panel_power_enable_out
);
// ----------------------------------------
// helper: last committed panel power bit
// ----------------------------------------
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
reg  pwr_bit;
wire ctrl_wr = psel && penable && pready && pwrite && paddr == `OFS_CTRL;
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		pwr_bit <= 1'b0;
	else if (ctrl_wr)
		pwr_bit <= pwdata[`CTRL_PANEL_PWR];
end
// one idle cycle sits between control writes, so two cycles is a safe look
property p_power; ctrl_wr |-> ##2 panel_power_enable_out == pwr_bit; endproperty
a_power: assert property (p_power) else $error("panel power not set");
property p_answer; psel && !penable |=> pready; endproperty
a_answer: assert property (p_answer) else $error("no ready after setup");
property p_io_reset; $rose(presetn) |-> general_io_oe_n == 3'h7; endproperty
a_io_reset: assert property (p_io_reset) else $error("gpio not input");
property p_one_mode; lane_enable == 8'h00 || lane_enable == 8'h0F || lane_enable == 8'hFF; endproperty
a_one_mode: assert property (p_one_mode) else $error("bad lane set");
property p_clk2_off; lane_enable == 8'h0F |-> !second_forwarded_clock; endproperty
a_clk2_off: assert property (p_clk2_off) else $error("clock two on");
property p_clk2_same; lane_enable == 8'hFF |-> second_forwarded_clock == first_forwarded_clock; endproperty
a_clk2_same: assert property (p_clk2_same) else $error("clocks differ");
property p_lane_hold; $changed(lane_low_word) |-> word_strobe; endproperty
a_lane_hold: assert property (p_lane_hold) else $error("lane moved");
property p_strobe; word_strobe |=> !word_strobe; endproperty
a_strobe: assert property (p_strobe) else $error("strobe too long");
property p_upper; pready && !pwrite && paddr == `OFS_SLAVE_ADDR |-> prdata[6:3] == 4'h7; endproperty
a_upper: assert property (p_upper) else $error("address top bits");
endmodule

// ==== verif/panel_rx_model.sv ====
// panel receiver model that captures each lane word pair
`timescale 1ns/1ps
module panel_rx_model (
	input wire        pclk,
	input wire        presetn,
	input wire        word_strobe,
	input wire [11:0] lane_low_word,
	input wire [11:0] lane_high_word,
	output reg [11:0] rx_low,
	output reg [11:0] rx_high,
	output reg [7:0]  rx_count
);
// ----------------------------------------
// capture on the strobe only, words between strobes carry no meaning
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		rx_count <= 8'h00;
	end else if (word_strobe) begin
		rx_low   <= lane_low_word; // full-colour panel: lane three in use, six-bit would leave it open
		rx_high  <= lane_high_word;
		rx_count <= rx_count + 8'h01;
	end
end
endmodule

// ==== verif/test_lvds_tx_pin_option_routing.sv ====
// self-checking bench for the pin option and pixel routing block
`timescale 1ns/1ps
`include "pin_option_map.vh"
module test_lvds_tx_pin_option_routing;
reg         pclk, presetn, psel, penable, pwrite, pixel_clock_in, pixel_valid_in;
reg         colour_map_strap, edge_select_strap, input_clock_invert_strap, balance_mode_strap;
reg  [11:0] paddr;
reg  [31:0] pwdata, rd;
reg  [23:0] pixel_input_bus;
reg  [1:0]  pixel_mode_strap;
reg  [3:0]  panel_select_straps;
reg  [2:0]  slave_addr_straps, general_io_in;
reg  [11:0] lo, hi;
reg  [7:0]  cnt0;
reg         er;
wire [31:0] prdata;
wire [2:0]  general_io_out, general_io_oe_n;
wire [11:0] lane_low_word, lane_high_word, rx_low, rx_high;
wire [7:0]  lane_enable, rx_count;
wire        pready, pslverr, first_forwarded_clock, second_forwarded_clock, word_strobe;
wire        panel_power_enable_out, backlight_enable_out, primary_sampling_edge;
integer     num_errors, checks_done, cycles, i;
pin_option_routing dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .pixel_clock_in, .pixel_input_bus, .pixel_valid_in, .pixel_mode_strap,
	.colour_map_strap, .edge_select_strap, .input_clock_invert_strap, .panel_select_straps,
	.slave_addr_straps, .balance_mode_strap, .general_io_in, .general_io_out, .general_io_oe_n,
	.lane_low_word, .lane_high_word, .lane_enable, .first_forwarded_clock,
	.second_forwarded_clock, .word_strobe, .panel_power_enable_out, .backlight_enable_out,
	.primary_sampling_edge);
panel_rx_model rx (.pclk, .presetn, .word_strobe, .lane_low_word, .lane_high_word, .rx_low,
	.rx_high, .rx_count);
// ----------------------------------------
// bus, compare and pixel tasks
// ----------------------------------------
task chk(input [31:0] exp, input [31:0] got);
	begin
		checks_done = checks_done + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	end
endtask
// one apb transfer, held until ready is seen at a rising edge
task apb(input w, input [11:0] a, input [31:0] d);
	begin
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	end
endtask
// data flips after the primary edge, so sampling on the wrong edge shows
task pix(input [23:0] d, input v);
	begin
		pixel_input_bus <= d;
		pixel_valid_in  <= v;
		repeat (4) @(posedge pclk);
		pixel_clock_in  <= edge_select_strap ^ input_clock_invert_strap;
		repeat (2) @(posedge pclk);
		pixel_input_bus <= ~d;
		repeat (2) @(posedge pclk);
		pixel_clock_in  <= ~(edge_select_strap ^ input_clock_invert_strap);
	end
endtask
task print_verdict;
	begin
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
endtask
// ----------------------------------------
// clock, hang limit and test sequence
// ----------------------------------------
initial begin
	pclk = 1'b0;
	forever #50 pclk = ~pclk;
end
always @(posedge pclk) begin
	cycles = cycles + 1;
	if (cycles == 5000) begin
		num_errors = num_errors + 1;
		print_verdict;
	end
end
initial begin
	{psel, penable, pwrite, paddr, pwdata, pixel_valid_in, pixel_input_bus} = 0;
	{num_errors, checks_done, cycles, colour_map_strap, input_clock_invert_strap} = 0;
	balance_mode_strap = 1'b0;
	{presetn, pixel_mode_strap, general_io_in, pixel_clock_in} = 0;
	{edge_select_strap, panel_select_straps, slave_addr_straps} = 8'h9D;
	repeat (10) @(posedge pclk);
	presetn <= 1'b1;
	repeat (30) @(posedge pclk);
	apb(0, `OFS_CTRL, 0);
	chk({28'h0, `CTRL_RESET}, rd);
	chk(3'h7, general_io_oe_n);
	apb(0, 12'h020, 0);
	chk(32'h1, {31'h0, er});
	chk(32'h0, rd);
	apb(0, `OFS_SLAVE_ADDR, 0);
	chk(32'h3D, rd);
	slave_addr_straps <= 3'h2;
	apb(0, `OFS_SLAVE_ADDR, 0);
	chk(32'h3D, rd);
	apb(0, `OFS_STRAPS, 0);
	chk(32'h43, rd);
	apb(1, `OFS_CTRL, 32'hB);
	apb(1, `OFS_GPIO_DIR, 32'h7);
	apb(1, `OFS_GPIO_OUT, 32'h5);
	general_io_in <= 3'h6;
	// the pin needs two edges through the synchroniser before the read samples it
	repeat (2) @(posedge pclk);
	apb(0, `OFS_STATUS, 0);
	chk(3'h6, rd[5:3]);
	chk(8'hC5, {panel_power_enable_out, backlight_enable_out, general_io_oe_n, general_io_out});
	apb(1, `OFS_CTRL, 32'hC);
	repeat (3) @(posedge pclk);
	chk(5'h07, {panel_power_enable_out, backlight_enable_out, general_io_oe_n});
	// modes: single/single, single/dual, dual/dual inverted clock, dual/dual swapped colours
	for (i = 0; i < 4; i = i + 1) begin
		pixel_mode_strap         <= (i == 0) ? `STRAP_LOW : (i == 1) ? `STRAP_MID : `STRAP_HIGH;
		colour_map_strap         <= (i == 3);
		input_clock_invert_strap <= (i == 2);
		edge_select_strap        <= (i != 1);
		@(posedge pclk);
		pixel_clock_in <= ~(edge_select_strap ^ input_clock_invert_strap);
		repeat (30) @(posedge pclk);
		chk((i == 0) ? 8'h0F : 8'hFF, lane_enable);
		chk(i != 1, primary_sampling_edge);
		apb(0, `OFS_STATUS, 0);
		chk((i == 0) ? `MODE_SISO : (i == 1) ? `MODE_SIDO : `MODE_DIDO, rd[2:1]);
		cnt0 = rx_count;
		pix(24'h5A3C81, 1'b1);
		pix(24'hC3E417, 1'b1);
		pix(24'h0FF0F0, 1'b0);
		repeat (10) @(posedge pclk);
		lo = (i == 1) ? 12'hC81 : 12'h417;
		hi = (i == 1) ? 12'h417 : 12'hC3E;
		if (i == 3) begin
			lo = {lo[5:0], lo[11:6]};
			hi = {hi[5:0], hi[11:6]};
		end
		chk((i == 1) ? 8'h01 : 8'h02, rx_count - cnt0);
		chk(lo, rx_low);
		if (i != 0)
			chk(hi, rx_high);
	end
	print_verdict;
end
endmodule
bind pin_option_routing pin_option_checker chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .general_io_oe_n, .lane_low_word, .lane_enable,
	.first_forwarded_clock, .second_forwarded_clock, .word_strobe, .panel_power_enable_out);
